/* File: design/cfg_pkg.sv */
package cfg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_CH    = 10;
  localparam int NUM_CAP   = 5;
  localparam int NUM_PAIRS = 4;
  localparam int NUM_RATES = 5;
  localparam int CNT_W     = 16;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_HZ         = 25_000_000;
  localparam int CRYSTAL_REF_HZ = 1_000_000;
  localparam int PRESCALE       = CLK_HZ / CRYSTAL_REF_HZ;
  localparam int DECADE         = 10;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map, byte offsets from the board base address
  localparam logic [11:0] BASE_ADDR  = 12'h300;
  localparam logic [11:0] CH_STRIDE  = 12'h010;
  localparam logic [1:0]  REG_CTRL   = 2'h0;
  localparam logic [1:0]  REG_PERIOD = 2'h1;
  localparam logic [1:0]  REG_DUTY   = 2'h2;
  localparam logic [1:0]  REG_RESULT = 2'h3;
  localparam logic [11:0] PAIR_OFS   = 12'h0a0;
  localparam logic [11:0] STATUS_OFS = 12'h0c0;

  ////////////////////////////////////////////////////////////////////////////////
  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RATE_LSB = 2;
  localparam int CTRL_SEQ_BIT  = 5;
  localparam int CTRL_IDLE_BIT = 6;
  localparam int CTRL_ARM_LSB  = 8;
  localparam int STATUS_RUN_BIT = 10;

  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] PERIOD_RST = 16'h000a;
  localparam logic [7:0]  DUTY_RST   = 8'h80;
  localparam logic [7:0]  ARM_HALF   = 8'h80;

  ////////////////////////////////////////////////////////////////////////////////
  // Channel modes
  localparam logic [1:0] MODE_GEN    = 2'h0;
  localparam logic [1:0] MODE_PERIOD = 2'h2;
  localparam logic [1:0] MODE_HIGH   = 2'h3;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN  = 2'b10
  } cfg_div_state_t;

endpackage

/* File: design/cfg_channel.sv */
`timescale 1ns/1ns
module cfg_channel (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [4:0]               rate_tick,
  input  wire logic [1:0]               mode,
  input  wire logic [2:0]               rate,
  input  wire logic                     seq_low_first,
  input  wire logic                     idle_level,
  input  wire logic                     armed,
  input  wire logic [15:0]              period,
  input  wire logic [7:0]               duty,
  input  wire logic                     gate_s,
  output logic                          wave,
  output logic [15:0]                   result,
  output logic                          done
);

  logic        tick;
  logic [15:0] cnt;
  logic [15:0] cap_cnt;
  logic [23:0] prod;
  logic [15:0] hi_ticks;
  logic [15:0] last;
  logic        gate_d;
  logic        rise;
  logic        fall;

  ////////////////////////////////////////////////////////////////////////////////
  // Rate selection; codes above the slowest map to the slowest
  always_comb begin
    if (rate >= 3'(cfg_pkg::NUM_RATES)) begin
      tick = rate_tick[cfg_pkg::NUM_RATES-1];
    end else begin
      tick = rate_tick[rate];
    end
  end

  assign prod     = period * duty;
  assign hi_ticks = prod[23:8];
  assign last     = (period == 16'h0000) ? 16'h0000 : period - 16'h0001;
  assign rise     = gate_s & ~gate_d;
  assign fall     = ~gate_s & gate_d;

  ////////////////////////////////////////////////////////////////////////////////
  // Generator: period counter runs on the base-rate tick
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cnt <= 16'h0000;
    end else if (mode != cfg_pkg::MODE_GEN || !armed) begin
      cnt <= 16'h0000;
    end else if (tick) begin
      cnt <= (cnt >= last) ? 16'h0000 : cnt + 16'h0001;
    end
  end

  // Duty fraction is a static setting, so the high part has a fixed share
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wave <= 1'b0;
    end else if (mode != cfg_pkg::MODE_GEN || !armed) begin
      wave <= idle_level;
    end else if (seq_low_first) begin
      wave <= (cnt >= period - hi_ticks);
    end else begin
      wave <= (cnt < hi_ticks);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Capture: counts saturate so a stalled input never wraps to a short value
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gate_d  <= 1'b0;
      cap_cnt <= 16'h0000;
      result  <= 16'h0000;
      done    <= 1'b0;
    end else begin
      gate_d <= gate_s;
      done   <= 1'b0;
      if (mode == cfg_pkg::MODE_PERIOD) begin
        // A tick on the restart cycle opens the new count, so none is lost
        if (rise) begin
          result  <= cap_cnt;
          cap_cnt <= {15'h0000, tick};
          done    <= 1'b1;
        end else if (tick && cap_cnt != 16'hffff) begin
          cap_cnt <= cap_cnt + 16'h0001;
        end
      end else if (mode == cfg_pkg::MODE_HIGH) begin
        if (rise) begin
          cap_cnt <= {15'h0000, tick};
        end else if (fall) begin
          result <= cap_cnt;
          done   <= 1'b1;
        end else if (tick && gate_s && cap_cnt != 16'hffff) begin
          cap_cnt <= cap_cnt + 16'h0001;
        end
      end else begin
        cap_cnt <= 16'h0000;
      end
    end
  end

endmodule // cfg_channel

/* File: design/cfg_top.sv */
`timescale 1ns/1ns
// How it works
// - Generator frequency follows host period value
// - Arm value below half disarms, else arms
// - Ten independent generator channels
// - Five decade base rates, 1 MHz to 100 Hz
// - Duty fraction fixed while running
// - High-low order starts with high part
// - Low-high order starts with low part
// - Duty fraction sets high part length
// - Disarmed output holds selectable idle level
// - Not running forces disarm
// - PWM capture: period and high-time counters
// - Results relative to base rate, plus duty
// - PWM capture only on pairs 1&2..4&5
// - Frequency capture on one gate input
// - Frequency capture on any of five channels
// - Decode at switch-set base address
module cfg_top (
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [11:0]              base_sw,
  input  wire logic                     app_running,
  input  wire logic [9:0]               gate_in,
  output logic [9:0]                    wave_out,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [11:0]              paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr
);

  localparam int NCH = cfg_pkg::NUM_CH;
  localparam int NP  = cfg_pkg::NUM_PAIRS;

  logic [15:0] ctrl   [NCH];
  logic [15:0] period [NCH];
  logic [7:0]  duty   [NCH];
  logic [15:0] result [NCH];
  logic [NCH-1:0] done;
  logic [NCH-1:0] wave;
  logic [NCH-1:0] armed;
  logic [7:0]  duty_frac [NP];

  logic [1:0]  gate_meta [NCH];
  logic [1:0]  run_sync;
  logic [11:0] base_q;
  logic [4:0]  rate_tick;
  logic [4:0]  pre_cnt;
  logic [3:0]  dec_cnt [4];

  logic [11:0] rel;
  logic [3:0]  ch_idx;
  logic [1:0]  reg_idx;
  logic        access;

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers; only the second stage of each pair is read by the logic
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      run_sync <= 2'b00;
    end else begin
      run_sync <= {run_sync[0], app_running};
    end
  end

  generate
    for (genvar g = 0; g < NCH; g++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          gate_meta[g] <= 2'b00;
        end else begin
          gate_meta[g] <= {gate_meta[g][0], gate_in[g]};
        end
      end
    end
  endgenerate

  // Base address switches are static; sampled every cycle from reset release
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      base_q <= cfg_pkg::BASE_ADDR;
    end else begin
      base_q <= base_sw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Base rates: the clock is divided down to the crystal reference, then decades
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pre_cnt      <= 5'h00;
      rate_tick[0] <= 1'b0;
    end else if (pre_cnt == 5'(cfg_pkg::PRESCALE - 1)) begin
      pre_cnt      <= 5'h00;
      rate_tick[0] <= 1'b1;
    end else begin
      pre_cnt      <= pre_cnt + 5'h01;
      rate_tick[0] <= 1'b0;
    end
  end

  generate
    for (genvar s = 0; s < 4; s++) begin : g_decade
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          dec_cnt[s]     <= 4'h0;
          rate_tick[s+1] <= 1'b0;
        end else begin
          rate_tick[s+1] <= 1'b0;
          if (rate_tick[s]) begin
            if (dec_cnt[s] == 4'(cfg_pkg::DECADE - 1)) begin
              dec_cnt[s]     <= 4'h0;
              rate_tick[s+1] <= 1'b1;
            end else begin
              dec_cnt[s] <= dec_cnt[s] + 4'h1;
            end
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Channels
  generate
    for (genvar c = 0; c < NCH; c++) begin : g_ch
      logic [1:0] mode_eff;

      // Capture modes exist only on the first five channels
      always_comb begin
        if (c < cfg_pkg::NUM_CAP) begin
          mode_eff = ctrl[c][cfg_pkg::CTRL_MODE_LSB +: 2];
        end else begin
          mode_eff = cfg_pkg::MODE_GEN;
        end
      end

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          armed[c] <= 1'b0;
        end else begin
          armed[c] <= run_sync[1] &&
                      ctrl[c][cfg_pkg::CTRL_ARM_LSB +: 8] >= cfg_pkg::ARM_HALF;
        end
      end

      cfg_channel u_ch (
        .ref_clk       (ref_clk),
        .srst          (srst),
        .rate_tick     (rate_tick),
        .mode          (mode_eff),
        .rate          (ctrl[c][cfg_pkg::CTRL_RATE_LSB +: 3]),
        .seq_low_first (ctrl[c][cfg_pkg::CTRL_SEQ_BIT]),
        .idle_level    (ctrl[c][cfg_pkg::CTRL_IDLE_BIT]),
        .armed         (armed[c]),
        .period        (period[c]),
        .duty          (duty[c]),
        .gate_s        (gate_meta[c][1]),
        .wave          (wave[c]),
        .result        (result[c]),
        .done          (done[c])
      );
    end
  endgenerate

  assign wave_out = wave;

  ////////////////////////////////////////////////////////////////////////////////
  localparam cfg_pkg::cfg_div_state_t DIV_IDLE_C = cfg_pkg::DIV_IDLE;
  localparam cfg_pkg::cfg_div_state_t DIV_RUN_C  = cfg_pkg::DIV_RUN;

  // Duty of each adjacent pair: high count over period count, 8 fraction bits.
  // Serial division costs ten cycles but avoids four wide dividers.
  generate
    for (genvar p = 0; p < NP; p++) begin : g_pair
      cfg_pkg::cfg_div_state_t st;
      logic [16:0] rem;
      logic [7:0]  quo;
      logic [3:0]  bits;
      logic [15:0] den;

      always_ff @(posedge ref_clk) begin
        if (srst) begin
          st           <= DIV_IDLE_C;
          rem          <= 17'h00000;
          quo          <= 8'h00;
          bits         <= 4'h0;
          den          <= 16'h0000;
          duty_frac[p] <= 8'h00;
        end else begin
          case (st)
            DIV_IDLE_C: begin
              if (done[p]) begin
                if (result[p] == 16'h0000) begin
                  duty_frac[p] <= 8'h00;
                end else if (result[p+1] >= result[p]) begin
                  duty_frac[p] <= 8'hff;
                end else begin
                  rem  <= {1'b0, result[p+1]};
                  den  <= result[p];
                  bits <= 4'h8;
                  st   <= DIV_RUN_C;
                end
              end
            end
            DIV_RUN_C: begin
              if (bits == 4'h0) begin
                duty_frac[p] <= quo;
                st           <= DIV_IDLE_C;
              end else if ({rem[15:0], 1'b0} >= {1'b0, den}) begin
                rem  <= {rem[15:0], 1'b0} - {1'b0, den};
                quo  <= {quo[6:0], 1'b1};
                bits <= bits - 4'h1;
              end else begin
                rem  <= {rem[15:0], 1'b0};
                quo  <= {quo[6:0], 1'b0};
                bits <= bits - 4'h1;
              end
            end
            default: st <= DIV_IDLE_C;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait state, answer registered
  assign rel     = paddr - base_q;
  assign ch_idx  = rel[7:4];
  assign reg_idx = rel[3:2];
  assign access  = psel & penable;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pready <= 1'b0;
    end else begin
      pready <= access & ~pready;
    end
  end

  // Writes land at the edge where the master sees pready
  generate
    for (genvar w = 0; w < NCH; w++) begin : g_wr
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          ctrl[w]   <= cfg_pkg::CTRL_RST;
          period[w] <= cfg_pkg::PERIOD_RST;
          duty[w]   <= cfg_pkg::DUTY_RST;
        end else if (access && pready && pwrite && rel < cfg_pkg::PAIR_OFS &&
                     ch_idx == 4'(w) && rel[1:0] == 2'b00) begin
          if (reg_idx == cfg_pkg::REG_CTRL) begin
            ctrl[w] <= pwdata[15:0];
          end else if (reg_idx == cfg_pkg::REG_PERIOD) begin
            period[w] <= pwdata[15:0];
          end else if (reg_idx == cfg_pkg::REG_DUTY) begin
            duty[w] <= pwdata[7:0];
          end
        end
      end
    end
  endgenerate

  // Read data and error are formed the cycle before pready rises
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (access && !pready) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      if (rel[1:0] != 2'b00) begin
        pslverr <= 1'b1;
      end else if (rel < cfg_pkg::PAIR_OFS) begin
        if (reg_idx == cfg_pkg::REG_CTRL) begin
          prdata <= {16'h0000, ctrl[ch_idx]};
        end else if (reg_idx == cfg_pkg::REG_PERIOD) begin
          prdata <= {16'h0000, period[ch_idx]};
        end else if (reg_idx == cfg_pkg::REG_DUTY) begin
          prdata <= {24'h000000, duty[ch_idx]};
        end else if (!pwrite) begin
          prdata <= {16'h0000, result[ch_idx]};
        end else begin
          pslverr <= 1'b1;
        end
      end else if (rel < cfg_pkg::PAIR_OFS + 12'h010 && !pwrite) begin
        prdata <= {24'h000000, duty_frac[rel[3:2]]};
      end else if (rel == cfg_pkg::STATUS_OFS && !pwrite) begin
        prdata <= {21'h0, run_sync[1], wave};
      end else begin
        pslverr <= 1'b1;
      end
    end
  end

endmodule // cfg_top

/* File: verif/cfg_chk.sv */
`timescale 1ns/1ns
module cfg_chk (
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        app_running,
  input  wire logic [9:0]  wave_out,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  default clocking dc @(posedge ref_clk); endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////////
  reset_out_a: assert property ($fell(srst) |-> wave_out == 10'h000 && !pready && prdata == 32'h0)
    else $error("outputs not cleared by reset");
  one_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  setup_quiet_a: assert property (psel && !penable |=> !pready)
    else $error("ready during first access cycle");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  ready_cause_a: assert property (pready |-> $past(psel && penable))
    else $error("ready without access");
  unaligned_err_a: assert property (psel && penable && !pready && paddr[1:0] != 2'h0
    |=> pready && pslverr)
    else $error("unaligned access not refused");
  err_cause_a: assert property ($rose(pslverr) |-> $past(psel && penable))
    else $error("error flag without access");
  rdata_hold_a: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  stop_still_a: assert property (!app_running [*8] |-> $stable(wave_out))
    else $error("outputs toggle while stopped");

  ////////////////////////////////////////////////////////////////////////////////
  cover property (pready && pslverr);
  cover property ($rose(wave_out[2]));
  cover property ($fell(app_running));
endmodule // cfg_chk

bind cfg_top cfg_chk chk_u (
  .ref_clk     (ref_clk),
  .srst        (srst),
  .app_running (app_running),
  .wave_out    (wave_out),
  .psel        (psel),
  .penable     (penable),
  .paddr       (paddr),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr)
);

/* File: verif/cfg_src.sv */
`timescale 1ns/1ns
module cfg_src (
  input  wire logic        ref_clk,
  input  wire logic        en,
  input  wire logic [15:0] hi_len,
  input  wire logic [15:0] per_len,
  output logic             sig
);
  logic [15:0] cnt = 16'h0000;

  // Held low while disabled, so a capture channel sees no stray edges
  always_ff @(posedge ref_clk) begin
    if (!en || cnt == per_len - 16'h0001) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end

  assign sig = en && (cnt < hi_len);
endmodule // cfg_src

/* File: verif/tb_counter_fm_gen_and_capture.sv */
`timescale 1ns/1ns
module tb_counter_fm_gen_and_capture;
  logic        ref_clk     = 1'b0;
  logic        srst        = 1'b1;
  logic [11:0] base_sw     = 12'h300;
  logic        app_running = 1'b0;
  logic [9:0]  gate_in;
  logic [9:0]  wave_out;
  logic        psel        = 1'b0;
  logic        penable     = 1'b0;
  logic        pwrite      = 1'b0;
  logic [11:0] paddr       = 12'h000;
  logic [31:0] pwdata      = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        src_en      = 1'b0;
  logic        src_sig;
  int          n_mismatch  = 0;
  int          num_checks  = 0;

  // Board clock; the 1 MHz reference is divided down from it
  always #20 ref_clk = ~ref_clk;

  // One source in parallel on both gates of a pair and on a lone counter
  assign gate_in = {5'h00, src_sig, 2'h0, src_sig, src_sig};

  cfg_top dut_u (
    .ref_clk(ref_clk), .srst(srst), .base_sw(base_sw), .app_running(app_running),
    .gate_in(gate_in), .wave_out(wave_out), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  // 250 clocks period, 75 high: exactly 10 and 3 ticks at 1 MHz
  cfg_src src_u (.ref_clk(ref_clk), .en(src_en), .hi_len(16'h004b), .per_len(16'h00fa),
    .sig(src_sig));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic experr, output logic [31:0] q);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    // A slave that never answers counts as a mismatch here
    chk("bus ready", 32'h1, {31'h0, pready});
    q = prdata;
    chk("error flag", {31'h0, experr}, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, experr, q);
    if (!experr) begin
      chk("read data", exp, q);
    end
  endtask

  function automatic logic [11:0] ra(input int ch, input logic [1:0] r);
    return cfg_pkg::BASE_ADDR + 12'(ch) * cfg_pkg::CH_STRIDE + {8'h00, r, 2'b00};
  endfunction

  function automatic logic [31:0] ctl(input logic [1:0] md, input int rate, input logic lowf,
                                     input logic idle, input logic [7:0] arm);
    return {16'h0, arm, 1'b0, idle, lowf, 3'(rate), md};
  endfunction

  // Skips the first high part, which arming may cut short, then counts a full period
  task automatic meas(input int ch, output int hi, output int per);
    int n = 0;
    while (wave_out[ch] !== 1'b1 && n < 60000) begin @(posedge ref_clk); n++; end
    while (wave_out[ch] !== 1'b0 && n < 60000) begin @(posedge ref_clk); n++; end
    while (wave_out[ch] !== 1'b1 && n < 60000) begin @(posedge ref_clk); n++; end
    hi = 0;
    while (wave_out[ch] === 1'b1 && hi < 60000) begin @(posedge ref_clk); hi++; end
    per = hi;
    while (wave_out[ch] === 1'b0 && per < 60000) begin @(posedge ref_clk); per++; end
  endtask

  task automatic first(input int ch, output logic v);
    logic s = wave_out[ch];
    int   n = 0;
    while (wave_out[ch] === s && n < 500) begin @(posedge ref_clk); n++; end
    v = wave_out[ch];
  endtask

  // Disarmed while reprogrammed, so a shorter period never meets a stale count
  task automatic gen(input int ch, input int rate, input int per, input int duty);
    int          hi;
    int          pd;
    int          base = 25 * (10 ** rate);
    logic [31:0] q;
    apb(1'b1, ra(ch, cfg_pkg::REG_CTRL), ctl(cfg_pkg::MODE_GEN, rate, 0, 0, 8'h00), 0, q);
    apb(1'b1, ra(ch, cfg_pkg::REG_PERIOD), 32'(per), 0, q);
    apb(1'b1, ra(ch, cfg_pkg::REG_DUTY), 32'(duty), 0, q);
    apb(1'b1, ra(ch, cfg_pkg::REG_CTRL), ctl(cfg_pkg::MODE_GEN, rate, 0, 0, 8'hff), 0, q);
    meas(ch, hi, pd);
    chk("high clocks", 32'(((per * duty) >> 8) * base), 32'(hi));
    chk("period clocks", 32'(per * base), 32'(pd));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic        v;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    app_running <= 1'b1;
    rd(ra(0, cfg_pkg::REG_CTRL), {16'h0, cfg_pkg::CTRL_RST}, 0);
    rd(ra(0, cfg_pkg::REG_PERIOD), {16'h0, cfg_pkg::PERIOD_RST}, 0);
    rd(ra(9, cfg_pkg::REG_DUTY), {24'h0, cfg_pkg::DUTY_RST}, 0);
    rd(ra(4, cfg_pkg::REG_RESULT), 32'h0, 0);
    rd(ra(0, cfg_pkg::REG_CTRL) + 12'h001, 32'h0, 1);
    apb(1'b1, ra(2, cfg_pkg::REG_RESULT), 32'h1234, 1, q);
    rd(12'h2fc, 32'h0, 1);
    rd(cfg_pkg::BASE_ADDR + 12'h0f0, 32'h0, 1);
    // Pair on counters 0 and 1, lone frequency capture on counter 4
    apb(1'b1, ra(0, 0), ctl(cfg_pkg::MODE_PERIOD, 0, 0, 0, 8'hff), 0, q);
    apb(1'b1, ra(1, 0), ctl(cfg_pkg::MODE_HIGH, 0, 0, 0, 8'hff), 0, q);
    apb(1'b1, ra(4, 0), ctl(cfg_pkg::MODE_PERIOD, 0, 0, 0, 8'hff), 0, q);
    src_en <= 1'b1;
    repeat (900) @(posedge ref_clk);
    rd(ra(0, cfg_pkg::REG_RESULT), 32'd10, 0);
    rd(ra(1, cfg_pkg::REG_RESULT), 32'd3, 0);
    rd(ra(4, cfg_pkg::REG_RESULT), 32'd10, 0);
    rd(cfg_pkg::BASE_ADDR + cfg_pkg::PAIR_OFS, 32'(3 * 256 / 10), 0);
    apb(1'b1, cfg_pkg::BASE_ADDR + cfg_pkg::PAIR_OFS, 32'h0, 1, q);
    src_en <= 1'b0;
    gen(2, 0, 4, 128);
    gen(2, 0, 8, 64);
    gen(9, 1, 2, 192);
    gen(5, 2, 2, 128);
    apb(1'b1, ra(3, 1), 32'h4, 0, q);
    apb(1'b1, ra(3, 0), ctl(cfg_pkg::MODE_GEN, 0, 1, 1, 8'h7f), 0, q);
    repeat (20) @(posedge ref_clk);
    chk("idle level below half", 32'h1, {31'h0, wave_out[3]});
    apb(1'b1, ra(3, 0), ctl(cfg_pkg::MODE_GEN, 0, 1, 1, cfg_pkg::ARM_HALF), 0, q);
    first(3, v);
    chk("low-high first level", 32'h0, {31'h0, v});
    apb(1'b1, ra(4, 0), ctl(cfg_pkg::MODE_GEN, 0, 0, 0, 8'hff), 0, q);
    first(4, v);
    chk("high-low first level", 32'h1, {31'h0, v});
    app_running <= 1'b0;
    repeat (12) @(posedge ref_clk);
    chk("stopped level ch3", 32'h1, {31'h0, wave_out[3]});
    chk("stopped level ch4", 32'h0, {31'h0, wave_out[4]});
    // Status: running flag clear, only channel 3 idles high
    rd(cfg_pkg::BASE_ADDR + cfg_pkg::STATUS_OFS, 32'h00000008, 0);
    test_done();
  end

  initial begin
    repeat (90000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
endmodule // tb_counter_fm_gen_and_capture
